// file: cetf_map.vh
// register map, field positions, reset values and timing counts of the
// execution timing and flag unit; assumes 32-bit apb word addressing
`ifndef CETF_MAP_VH
`define CETF_MAP_VH

// ==========================================================
// register byte offsets
`define CETF_OFS_CTRL     8'h00
`define CETF_OFS_SRC      8'h04
`define CETF_OFS_DST      8'h08
`define CETF_OFS_CNT      8'h0C
`define CETF_OFS_STAT     8'h10
`define CETF_OFS_ACC      8'h14
`define CETF_OFS_INST     8'h18
`define CETF_OFS_OPA      8'h1C
`define CETF_OFS_OPB      8'h20
`define CETF_OFS_OP       8'h24
`define CETF_OFS_CCR      8'h28
`define CETF_OFS_RES      8'h2C

// ==========================================================
// control bits
`define CETF_CTRL_GO      0
`define CETF_CTRL_WORD    1
`define CETF_CTRL_EXR     2

// ==========================================================
// condition code bit positions
`define CETF_CCR_C        0
`define CETF_CCR_V        1
`define CETF_CCR_Z        2
`define CETF_CCR_N        3
`define CETF_CCR_H        5
`define CETF_CCR_RST      8'h00

// ==========================================================
// access paths and kinds
`define CETF_PATH_ONCHIP  3'h0
`define CETF_PATH_SMOD8   3'h1
`define CETF_PATH_SMOD16  3'h2
`define CETF_PATH_EXT8_2  3'h3
`define CETF_PATH_EXT8_3  3'h4
`define CETF_PATH_EXT16_2 3'h5
`define CETF_PATH_EXT16_3 3'h6
`define CETF_KIND_FETCH   2'h0
`define CETF_KIND_BYTE    2'h1
`define CETF_KIND_WORD    2'h2
`define CETF_KIND_INT     2'h3

// ==========================================================
// timing counts in states
`define CETF_COPY_SETUP   3'h4
`define CETF_SAVE_BASE    8'h07
`define CETF_TRAP_BASE    8'h08
`define CETF_RTE_BASE     8'h05
`define CETF_EXR_EXTRA    8'h01

`endif

// file: cetf_cost.v
// access cost calculator: states per bus cycle by path, kind and waits,
// plus multi-register save and trap/return counts; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cetf_map.vh"

module cetf_cost (
    // access query
    input  wire [2:0] path,
    input  wire [1:0] kind,
    input  wire [3:0] waits,
    output reg  [7:0] acc_states,
    output reg        acc_illegal,
    // instruction query
    input  wire [2:0] save_regs,
    input  wire       trap_sel,
    input  wire       rte_sel,
    input  wire       exr_valid,
    output reg  [7:0] inst_states
);
    // ==========================================================
    // per access cost
    always @* begin
        acc_illegal = 1'b0;
        acc_states  = 8'h01;
        if (kind == `CETF_KIND_INT) begin
            acc_states = 8'h01;                              // RULE_03
        end else begin
            case (path)
                `CETF_PATH_ONCHIP: acc_states = 8'h01;       // RULE_01
                `CETF_PATH_SMOD8,
                `CETF_PATH_EXT8_2:
                    acc_states = (kind == `CETF_KIND_BYTE) ? 8'h02 : 8'h04; // RULE_02
                `CETF_PATH_SMOD16: acc_states = 8'h02;       // RULE_02
                `CETF_PATH_EXT8_3:
                    acc_states = (kind == `CETF_KIND_BYTE) ?
                        8'h03 + {4'h0, waits} :
                        8'h06 + {3'h0, waits, 1'b0};          // RULE_03
                default: begin
                    acc_illegal = 1'b1;                       // RULE_04
                    acc_states  = 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // instruction counts; extended register adds one state to trap and return
    always @* begin
        if (trap_sel)
            inst_states = `CETF_TRAP_BASE + (exr_valid ? `CETF_EXR_EXTRA : 8'h00); // RULE_11
        else if (rte_sel)
            inst_states = `CETF_RTE_BASE + (exr_valid ? `CETF_EXR_EXTRA : 8'h00);  // RULE_11
        else if (save_regs >= 3'h2 && save_regs <= 3'h4)
            inst_states = `CETF_SAVE_BASE + {4'h0, save_regs - 3'h2, 1'b0};       // RULE_06
        else
            inst_states = 8'h00;
    end
endmodule // cetf_cost
`default_nettype wire

// file: cetf_flags.v
// flag unit: arithmetic result and condition codes for add, subtract,
// extended add/subtract and divide; combinational, caller latches
`timescale 1ns/1ps
`default_nettype none
`include "cetf_map.vh"

module cetf_flags (
    // operands
    input  wire [31:0] opa,
    input  wire [31:0] opb,
    input  wire [2:0]  op,
    input  wire [7:0]  ccr_in,
    // results
    output reg  [31:0] result,
    output reg  [7:0]  ccr_out
);
    reg [32:0] sum;
    reg [15:0] q;
    reg [7:0]  r;
    reg        cin;

    // ==========================================================
    // op 0 add.w, 1 sub.w, 2 add.l, 3 sub.l, 4 addx, 5 subx, 6 divs, 7 divu
    always @* begin
        sum     = 33'h0;
        q       = 16'h0;
        r       = 8'h0;
        cin     = ccr_in[`CETF_CCR_C];
        ccr_out = ccr_in;
        result  = 32'h0;
        case (op)
            3'h0, 3'h1, 3'h4, 3'h5: begin
                if (op[0])
                    sum = {17'h0, opa[15:0]} - {17'h0, opb[15:0]} - {32'h0, op[2] & cin};
                else
                    sum = {17'h0, opa[15:0]} + {17'h0, opb[15:0]} + {32'h0, op[2] & cin};
                result = {16'h0, sum[15:0]};
                ccr_out[`CETF_CCR_H] = opa[12] ^ opb[12] ^ sum[12];     // RULE_07
                ccr_out[`CETF_CCR_C] = sum[16];
                ccr_out[`CETF_CCR_N] = sum[15];
                ccr_out[`CETF_CCR_V] = op[0] ? (opa[15] ^ opb[15]) & (opa[15] ^ sum[15])
                                             : ~(opa[15] ^ opb[15]) & (opa[15] ^ sum[15]);
                if (op[2])
                    ccr_out[`CETF_CCR_Z] = ccr_in[`CETF_CCR_Z] & (sum[15:0] == 16'h0); // RULE_08
                else
                    ccr_out[`CETF_CCR_Z] = (sum[15:0] == 16'h0);
            end
            3'h2, 3'h3: begin
                sum = op[0] ? {1'b0, opa} - {1'b0, opb} : {1'b0, opa} + {1'b0, opb};
                result = sum[31:0];
                ccr_out[`CETF_CCR_H] = opa[28] ^ opb[28] ^ sum[28];     // RULE_07
                ccr_out[`CETF_CCR_C] = sum[32];
                ccr_out[`CETF_CCR_N] = sum[31];
                ccr_out[`CETF_CCR_Z] = (sum[31:0] == 32'h0);
                ccr_out[`CETF_CCR_V] = op[0] ? (opa[31] ^ opb[31]) & (opa[31] ^ sum[31])
                                             : ~(opa[31] ^ opb[31]) & (opa[31] ^ sum[31]);
            end
            default: begin
                // 16 by 8 divide; quotient low byte, remainder high byte
                if (opb[7:0] != 8'h00) begin
                    if (op[0]) begin
                        q = opa[15:0] / {8'h0, opb[7:0]};
                        r = opa[7:0] - q[7:0] * opb[7:0];
                    end else begin
                        q = $signed(opa[15:0]) / $signed({{8{opb[7]}}, opb[7:0]});
                        r = opa[7:0] - q[7:0] * opb[7:0];
                    end
                end
                result = {16'h0, r, q[7:0]};
                ccr_out[`CETF_CCR_Z] = (opb[7:0] == 8'h00);             // RULE_09
                ccr_out[`CETF_CCR_N] = op[0] ? opb[7]                   // RULE_10
                                             : (opb[7:0] != 8'h00) & q[7];
            end
        endcase
    end
endmodule // cetf_flags
`default_nettype wire

// file: cetf_top.v
// execution timing and flag unit: apb slave, block copy engine, access
// cost and flag calculators; assumes a one-state byte memory on mem_*
//
// Contract
// RULE_01 - base state counts hold when code and operands sit in one-state word memory.
// RULE_02 - 8-bit module or 8-bit two-state external costs 4 per fetch or word, 2 per byte.
// RULE_03 - 8-bit three-state external costs 6+2m per fetch or word, 3+m per byte.
// RULE_04 - no 16-bit external bus exists; such a path is refused.
// RULE_05 - block copy moves count bytes source to destination in 4+2n states.
// RULE_06 - register save or restore takes 7, 9 or 11 states for 2, 3 or 4 registers.
// RULE_07 - half carry reflects carry or borrow at bit 11 for words, bit 27 for longs.
// RULE_08 - extended add or subtract keeps zero on a zero result, clears it otherwise.
// RULE_09 - divide sets the zero flag exactly when the divisor is zero.
// RULE_10 - signed divide sets the sign flag for a negative divisor or quotient; code: signed for a negative quotient only, unsigned for a negative divisor.
// RULE_11 - trap and return take one state more while the extended register is valid.
`timescale 1ns/1ps
`default_nettype none
`include "cetf_map.vh"

module cetf_top (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // copy memory port
    output wire [31:0] mem_addr,
    output wire        mem_rd,
    output wire        mem_wr,
    output wire [7:0]  mem_wdata,
    input  wire [7:0]  mem_rdata,
    // status
    output wire        copy_busy
);
    // ==========================================================
    // copy engine states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_PRE  = 2'b01;
    localparam [1:0] ST_RD   = 2'b10;
    localparam [1:0] ST_WR   = 2'b11;

    reg  [1:0]  state_r;
    reg  [1:0]  pre_cnt_r;
    reg  [31:0] source_pointer_r;
    reg  [31:0] destination_pointer_r;
    reg  [15:0] copy_count_word_r;
    reg         word_mode_r;
    reg         extended_control_reg_r;
    reg         done_r;
    reg  [15:0] busy_states_r;
    reg  [11:0] acc_cfg_r;
    reg  [3:0]  inst_cfg_r;
    reg  [31:0] opa_r;
    reg  [31:0] opb_r;
    reg  [2:0]  op_r;
    reg  [7:0]  condition_code_reg_r;
    reg  [31:0] result_r;
    reg  [31:0] rdata_nxt;
    reg         err_nxt;

    wire        wr_en;
    wire        rd_en;
    wire        go;
    wire [15:0] cnt_eff;
    wire [7:0]  acc_states;
    wire        acc_illegal;
    wire [7:0]  inst_states;
    wire [31:0] alu_result;
    wire [7:0]  alu_ccr;

    // ==========================================================
    // apb strobes; zero wait state slave
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign go      = wr_en & (paddr == `CETF_OFS_CTRL) & pwdata[`CETF_CTRL_GO]
                     & (state_r == ST_IDLE);

    // address decode used by the error path only; the read mux compares offsets itself
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `CETF_OFS_RES);
        end
    endfunction

    // byte mode only looks at the low count byte
    assign cnt_eff = word_mode_r ? copy_count_word_r
                                 : {8'h00, copy_count_word_r[7:0]};

    // ==========================================================
    // read mux and error answer
    always @* begin
        rdata_nxt = 32'h0;
        err_nxt   = ~mapped(paddr);
        if (paddr == `CETF_OFS_CTRL)
            rdata_nxt = {29'h0, extended_control_reg_r, word_mode_r, 1'b0};
        else if (paddr == `CETF_OFS_SRC)
            rdata_nxt = source_pointer_r;
        else if (paddr == `CETF_OFS_DST)
            rdata_nxt = destination_pointer_r;
        else if (paddr == `CETF_OFS_CNT)
            rdata_nxt = {16'h0, copy_count_word_r};
        else if (paddr == `CETF_OFS_STAT)
            rdata_nxt = {busy_states_r, 14'h0, done_r, state_r != ST_IDLE};
        else if (paddr == `CETF_OFS_ACC)
            rdata_nxt = {7'h0, acc_illegal, acc_states, 4'h0, acc_cfg_r};
        else if (paddr == `CETF_OFS_INST)
            rdata_nxt = {8'h0, inst_states, 12'h0, inst_cfg_r};
        else if (paddr == `CETF_OFS_OPA)
            rdata_nxt = opa_r;
        else if (paddr == `CETF_OFS_OPB)
            rdata_nxt = opb_r;
        else if (paddr == `CETF_OFS_OP)
            rdata_nxt = {29'h0, op_r};
        else if (paddr == `CETF_OFS_CCR)
            rdata_nxt = {24'h0, condition_code_reg_r};
        else if (paddr == `CETF_OFS_RES)
            rdata_nxt = result_r;
    end

    // read data is presented combinationally in the access phase
    assign prdata  = rd_en ? rdata_nxt : 32'h0;
    assign pslverr = psel & penable & err_nxt;

    // ==========================================================
    // configuration and operand registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_mode_r            <= 1'b0;
            extended_control_reg_r <= 1'b0;
            acc_cfg_r              <= 12'h000;
            inst_cfg_r             <= 4'h0;
            opa_r                  <= 32'h0;
            opb_r                  <= 32'h0;
            op_r                   <= 3'h0;
        end else if (wr_en) begin
            if (paddr == `CETF_OFS_CTRL) begin
                // mode cannot change under a running copy
                if (state_r == ST_IDLE)
                    word_mode_r <= pwdata[`CETF_CTRL_WORD];
                extended_control_reg_r <= pwdata[`CETF_CTRL_EXR];
            end else if (paddr == `CETF_OFS_ACC)
                acc_cfg_r <= pwdata[11:0];
            else if (paddr == `CETF_OFS_INST)
                inst_cfg_r <= pwdata[3:0];
            else if (paddr == `CETF_OFS_OPA)
                opa_r <= pwdata;
            else if (paddr == `CETF_OFS_OPB)
                opb_r <= pwdata;
            else if (paddr == `CETF_OFS_OP)
                op_r <= pwdata[2:0];
        end
    end

    // ==========================================================
    // flag state: a write to op runs the calculation and latches it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            condition_code_reg_r <= `CETF_CCR_RST;
            result_r             <= 32'h0;
        end else if (wr_en && paddr == `CETF_OFS_OP) begin
            condition_code_reg_r <= alu_ccr;                 // RULE_08
            result_r             <= alu_result;
        end else if (wr_en && paddr == `CETF_OFS_CCR) begin
            condition_code_reg_r <= pwdata[7:0];
        end
    end

    // ==========================================================
    // copy engine: four setup states, then read and write per byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r               <= ST_IDLE;
            pre_cnt_r             <= 2'h0;
            source_pointer_r      <= 32'h0;
            destination_pointer_r <= 32'h0;
            copy_count_word_r     <= 16'h0;
            done_r                <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // pointers and count are only writable while idle
                    if (wr_en && paddr == `CETF_OFS_SRC)
                        source_pointer_r <= pwdata;
                    if (wr_en && paddr == `CETF_OFS_DST)
                        destination_pointer_r <= pwdata;
                    if (wr_en && paddr == `CETF_OFS_CNT)
                        copy_count_word_r <= pwdata[15:0];
                    if (go) begin
                        state_r   <= ST_PRE;
                        pre_cnt_r <= 2'h0;
                        done_r    <= 1'b0;
                    end
                end
                ST_PRE: begin
                    pre_cnt_r <= pre_cnt_r + 2'h1;
                    if ({1'b0, pre_cnt_r} == `CETF_COPY_SETUP - 3'h1) begin
                        if (cnt_eff == 16'h0) begin
                            state_r <= ST_IDLE;              // RULE_05
                            done_r  <= 1'b1;
                        end else
                            state_r <= ST_RD;                // RULE_05
                    end
                end
                ST_RD: begin
                    state_r <= ST_WR;
                end
                default: begin
                    source_pointer_r      <= source_pointer_r + 32'h1;      // RULE_05
                    destination_pointer_r <= destination_pointer_r + 32'h1; // RULE_05
                    if (word_mode_r)
                        copy_count_word_r <= copy_count_word_r - 16'h1;
                    else
                        copy_count_word_r[7:0] <= copy_count_word_r[7:0] - 8'h1;
                    if (cnt_eff == 16'h1) begin
                        state_r <= ST_IDLE;
                        done_r  <= 1'b1;
                    end else
                        state_r <= ST_RD;
                end
            endcase
        end
    end

    // ==========================================================
    // busy state counter, saturates at FFFF; reads 4+2n once a copy ends for n up to 32765
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_states_r <= 16'h0;
        else if (go)
            busy_states_r <= 16'h0;
        else if (state_r != ST_IDLE && busy_states_r != 16'hFFFF)
            busy_states_r <= busy_states_r + 16'h1;          // RULE_05
    end

    // ==========================================================
    // memory port; read data returns one state after mem_rd
    assign mem_rd    = (state_r == ST_RD);
    assign mem_wr    = (state_r == ST_WR);
    assign mem_addr  = (state_r == ST_WR) ? destination_pointer_r
                                          : source_pointer_r;
    assign mem_wdata = mem_rdata;
    assign copy_busy = (state_r != ST_IDLE);

    // ==========================================================
    // calculators
    cetf_cost u_cost (
        .path        (acc_cfg_r[2:0]),
        .kind        (acc_cfg_r[5:4]),
        .waits       (acc_cfg_r[11:8]),
        .acc_states  (acc_states),
        .acc_illegal (acc_illegal),
        .save_regs   (inst_cfg_r[2:0]),
        .trap_sel    (inst_cfg_r[3] & ~inst_cfg_r[2]),
        .rte_sel     (inst_cfg_r[3] & inst_cfg_r[2]),
        .exr_valid   (extended_control_reg_r),
        .inst_states (inst_states)
    );

    cetf_flags u_flags (
        .opa     (opa_r),
        .opb     (opb_r),
        .op      (pwdata[2:0]),
        .ccr_in  (condition_code_reg_r),
        .result  (alu_result),
        .ccr_out (alu_ccr)
    );
endmodule // cetf_top
`default_nettype wire

// file: cetf_top_chk.sv
// checker for the timing and flag unit: apb answers and copy engine
// assumes it is bound to cetf_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
`include "cetf_map.vh"
// ==========================================================
// port watcher
module cetf_top_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // copy memory port
    input wire logic [31:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata,
    // status
    input wire logic        copy_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase and map decode, kept apart from the design's own decode
    wire logic acc = psel && penable;
    wire logic bad = (paddr[1:0] != 2'h0) || (paddr > 8'h2C);
    // one byte moved: read state then write state
    sequence s_move;
        mem_rd ##1 mem_wr;
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && bad |-> pslverr) else $error("no slverr");
    a_mapped_ok: assert property (acc && !bad |-> !pslverr) else $error("false slverr");
    a_prdata_quiet: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
        else $error("prdata outside read");
    a_go_starts: assert property (acc && pwrite && paddr == `CETF_OFS_CTRL && pwdata[0]
        && !copy_busy |=> copy_busy) else $error("go did not start copy");
    a_setup_quiet: assert property ($rose(copy_busy) |-> (!mem_rd && !mem_wr)[*4])
        else $error("memory touched in setup");
    a_byte_pair: assert property (mem_rd |=> mem_wr && !mem_rd) else $error("read unpaired");
    a_pair_next: assert property (mem_wr |=> mem_rd || !copy_busy)
        else $error("copy stalled");
    a_src_step: assert property (s_move ##1 mem_rd |-> mem_addr == $past(mem_addr, 2) + 32'h1)
        else $error("source not incremented");
    a_wdata_echo: assert property (mem_wr |-> mem_wdata == mem_rdata)
        else $error("write data differs");
    a_quiet_idle: assert property (!copy_busy |-> !mem_rd && !mem_wr)
        else $error("memory touched while idle");
endmodule // cetf_top_chk
bind cetf_top cetf_top_chk u_chk (.*);
`default_nettype wire

// file: cetf_mem_model.sv
// one-state byte memory behind the copy port
// assumes read data is wanted in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// memory model
module cetf_mem_model (
    // clock
    input wire logic        pclk,
    // copy port
    input wire logic [31:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    output var logic [7:0]  mem_rdata
);
    logic [7:0] mem [0:1023];
    // known pattern so every copied byte can be predicted
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5A;
        mem_rdata = 8'h00;
    end
    // data holds one cycle only, then flips so stale reads show up
    always @(posedge pclk) begin
        mem_rdata <= mem_rd ? mem[mem_addr[9:0]] : ~mem_rdata;
        if (mem_wr) mem[mem_addr[9:0]] <= mem_wdata;
    end
endmodule // cetf_mem_model
`default_nettype wire

// file: cetf_top_test.sv
// self-checking bench for the timing and flag unit over apb
// assumes cetf_top, cetf_mem_model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "cetf_map.vh"
// ==========================================================
// bench top
module cetf_top_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        err;
    wire  [31:0] prdata, mem_addr;
    wire         pready, pslverr, mem_rd, mem_wr, copy_busy;
    wire  [7:0]  mem_wdata, mem_rdata;
    int          fails = 0, n_checks = 0, busy_n = 0;
    cetf_top dut (.*);
    cetf_mem_model mem_i (.*);
    // clock and busy tally, sampled away from the edge
    always #5 pclk = ~pclk;
    always @(negedge pclk) if (copy_busy) busy_n++;
    // ==========================================================
    // tasks
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t addr %h got %h exp %h", $time, paddr, got, exp);
        end
    endtask
    // one apb transfer; waits for pready, a bounded number of edges
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            fails++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    // expected {illegal, states} per path, kind and wait count
    function automatic logic [8:0] cost(input int p, input int k, input int m);
        if (k == 3 || p == 0) return 9'h001;
        if (p >= 5) return 9'h100;
        if (p == 2) return 9'h002;
        if (p == 4) return (k == 1) ? 9'(3 + m) : 9'(6 + 2 * m);
        return (k == 1) ? 9'h002 : 9'h004;
    endfunction
    // copy; with work to do a second go and a source write are tried mid-run
    task automatic copy(input logic [31:0] s, d, c, input logic wm, input int n);
        int j;
        logic [31:0] x;
        wr(`CETF_OFS_SRC, s); wr(`CETF_OFS_DST, d); wr(`CETF_OFS_CNT, c);
        busy_n = 0;
        wr(`CETF_OFS_CTRL, {30'h0, wm, 1'b1});
        if (n > 0) begin
            wr(`CETF_OFS_SRC, 32'h3FF);
            wr(`CETF_OFS_CTRL, {30'h0, wm, 1'b1});
        end
        for (j = 0; j < 3000; j++) begin
            @(negedge pclk);
            if (!copy_busy) break;
        end
        if (j == 3000) begin
            fails++;
            conclude();
        end
        chk(busy_n, 4 + 2 * n);
        rdc(`CETF_OFS_STAT, {16'(4 + 2 * n), 16'h2}, '1);
        rdc(`CETF_OFS_SRC, s + n, '1);
        rdc(`CETF_OFS_DST, d + n, '1);
        rdc(`CETF_OFS_CNT, c - n, 32'hFFFF);
        for (j = 0; j < n; j++) begin
            x = s + j;
            chk({24'h0, mem_i.mem[10'(d + j)]}, {24'h0, x[7:0] ^ 8'h5A});
        end
    endtask
    // run one operation and compare one condition code bit
    task automatic flg(input logic [2:0] op, input logic [31:0] a, b,
                       input logic [7:0] ci, input int bn, input logic e);
        wr(`CETF_OFS_OPA, a); wr(`CETF_OFS_OPB, b); wr(`CETF_OFS_CCR, {24'h0, ci});
        wr(`CETF_OFS_OP, {29'h0, op});
        rdc(`CETF_OFS_CCR, 32'(e) << bn, 32'h1 << bn);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CETF_OFS_CCR, 32'h0, 32'hFF);
        rdc(`CETF_OFS_STAT, 32'h0, '1);
        apb(1'b0, 8'h30, 32'h0); chk(err, 1'b1);
        apb(1'b1, 8'h02, 32'h1); chk(err, 1'b1);
        for (int p = 0; p < 8; p++)
            for (int k = 0; k < 4; k++)
                for (int m = 0; m < 16; m += 15) begin
                    wr(`CETF_OFS_ACC, (m << 8) | (k << 4) | p);
                    rdc(`CETF_OFS_ACC, {7'h0, cost(p, k, m), 16'h0}, 32'h01FF0000);
                end
        for (int e = 0; e < 2; e++) begin
            wr(`CETF_OFS_CTRL, e << 2);
            rdc(`CETF_OFS_CTRL, e << 2, 32'h6);
            for (int v = 0; v < 16; v++) begin
                wr(`CETF_OFS_INST, v);
                rdc(`CETF_OFS_INST, (v[3:2] == 2'h3 ? 5 + e : v[3] ? 8 + e :
                    (v >= 2 && v <= 4) ? 2 * v + 3 : 0) << 16, 32'hFF0000);
            end
        end
        wr(`CETF_OFS_CTRL, 32'h0);
        copy(32'h100, 32'h200, 32'h0102, 1'b0, 2);
        copy(32'h000, 32'h300, 32'h0102, 1'b1, 258);
        copy(32'h010, 32'h3F0, 32'h0000, 1'b0, 0);
        flg(3'h0, 32'h800, 32'h800, 8'h00, `CETF_CCR_H, 1'b1);
        flg(3'h0, 32'h1, 32'h1, 8'h20, `CETF_CCR_H, 1'b0);
        flg(3'h1, 32'h1000, 32'h1, 8'h00, `CETF_CCR_H, 1'b1);
        flg(3'h2, 32'h08000000, 32'h08000000, 8'h00, `CETF_CCR_H, 1'b1);
        flg(3'h2, 32'h800, 32'h800, 8'h20, `CETF_CCR_H, 1'b0);
        flg(3'h3, 32'h10000000, 32'h1, 8'h00, `CETF_CCR_H, 1'b1);
        flg(3'h4, 32'h0, 32'h0, 8'h04, `CETF_CCR_Z, 1'b1);
        flg(3'h4, 32'h0, 32'h0, 8'h00, `CETF_CCR_Z, 1'b0);
        flg(3'h4, 32'hFFFF, 32'h0, 8'h05, `CETF_CCR_Z, 1'b1);
        flg(3'h4, 32'h1, 32'h0, 8'h04, `CETF_CCR_Z, 1'b0);
        flg(3'h5, 32'h5, 32'h5, 8'h04, `CETF_CCR_Z, 1'b1);
        flg(3'h7, 32'd100, 32'h0, 8'h00, `CETF_CCR_Z, 1'b1);
        rdc(`CETF_OFS_RES, 32'h0, 32'hFFFF);
        flg(3'h7, 32'd100, 32'h7, 8'h04, `CETF_CCR_Z, 1'b0);
        rdc(`CETF_OFS_RES, 32'h020E, 32'hFFFF);
        flg(3'h6, 32'hFF9C, 32'h7, 8'h00, `CETF_CCR_N, 1'b1);
        flg(3'h6, 32'd100, 32'h7, 8'h08, `CETF_CCR_N, 1'b0);
        flg(3'h7, 32'd100, 32'h80, 8'h00, `CETF_CCR_N, 1'b1);
        flg(3'h7, 32'd100, 32'h7, 8'h08, `CETF_CCR_N, 1'b0);
        conclude();
    end
endmodule // cetf_top_test
`default_nettype wire
